// File: timer16_defines.vh
// Offsets, field positions, reset values and timing counts of the 16-bit timer
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets on the 8-bit I/O bus
// ----------------------------------------------------------------------------
`define OFS_CONTROL_A      6'h00
`define OFS_CONTROL_B      6'h01
`define OFS_COUNTER_LOWER  6'h02
`define OFS_COUNTER_UPPER  6'h03
`define OFS_CAPTURE_LOWER  6'h04
`define OFS_CAPTURE_UPPER  6'h05
`define OFS_FLAGS          6'h06
`define OFS_MASK           6'h07
`define OFS_COMPARATOR_SEL 6'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRLA_MODE_LO      1:0
`define CTRLB_FILTER_BIT   7
`define CTRLB_EDGE_BIT     6
`define CTRLB_MODE_HI      4:3
`define CTRLB_CLKSEL       2:0
`define FLAG_OVERFLOW_BIT  0
`define FLAG_CAPTURE_BIT   5
`define CMPSEL_BIT         0

// ----------------------------------------------------------------------------
// Reset values and fixed tops
// ----------------------------------------------------------------------------
`define RESET_BYTE         8'h00
`define RESET_WORD         16'h0000
`define TOP_MAX            16'hFFFF
`define TOP_8BIT           16'h00FF
`define TOP_9BIT           16'h01FF
`define TOP_10BIT          16'h03FF

// ----------------------------------------------------------------------------
// Clock select codes and timing counts
// ----------------------------------------------------------------------------
`define CS_STOP            3'h0
`define CS_DIV1            3'h1
`define CS_DIV8            3'h2
`define CS_DIV64           3'h3
`define CS_DIV256          3'h4
`define CS_DIV1024         3'h5
`define CS_EXT_FALL        3'h6
`define CS_EXT_RISE        3'h7
`define FILTER_SAMPLES     4

`endif

// File: input_conditioner.v
// Two-stage synchroniser followed by an optional four-sample noise filter
`timescale 1ns/10ps
`include "timer16_defines.vh"

module input_conditioner (
  input  wire clock,
  input  wire nrst,
  input  wire raw_in,
  input  wire filter_on,
  output reg  level_out
);

  reg                          sync_a;
  reg                          sync_b;
  reg [`FILTER_SAMPLES-1:0]    history;

  // ----------------------------------------------------------------------------
  // Synchroniser; sync_a is read only by sync_b
  // ----------------------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------------------
  // Filter: output follows only after four equal samples, on the system clock
  // ----------------------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      history   <= {`FILTER_SAMPLES{1'b0}};
      level_out <= 1'b0;
    end else begin
      history <= {history[`FILTER_SAMPLES-2:0], sync_b};
      if (!filter_on)
        level_out <= sync_b;
      else if (&history)
        level_out <= 1'b1;
      else if (~|history)
        level_out <= 1'b0;
    end
  end

endmodule // input_conditioner

// File: timer16_counter_capture.v
// 16-bit timer counter with shared upper-byte holding register and input capture
`timescale 1ns/10ps
`include "timer16_defines.vh"

module timer16_counter_capture #(
  parameter INSTANCE_ONE = 1
) (
  input  wire        clock,
  input  wire        nrst,
  input  wire [5:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        io_wr,
  input  wire        io_rd,
  output reg  [7:0]  io_rdata,
  input  wire        capture_pin,
  input  wire        comparator_output,
  input  wire        ext_clock_pin,
  input  wire [15:0] compare_a_top,
  input  wire        overflow_irq_ack,
  input  wire        capture_irq_ack,
  output reg         overflow_irq,
  output reg         capture_irq,
  output reg  [15:0] count_value,
  output reg         top_hit,
  output reg         bottom_hit,
  output reg         count_down
);

  reg  [7:0]  control_reg_a;
  reg  [7:0]  control_reg_b;
  reg  [7:0]  holding_byte;
  reg  [15:0] capture_value;
  reg         overflow_flag;
  reg         capture_flag;
  reg         overflow_irq_enable;
  reg         capture_irq_enable;
  reg         comparator_capture_select;
  reg  [9:0]  prescale;
  reg         ext_prev;
  reg         capture_prev;
  reg  [15:0] next_count;
  reg         next_down;
  reg         overflow_event;
  reg         timer_tick;
  reg  [15:0] top_value;
  wire [3:0]  waveform_mode_field;
  wire [2:0]  clock_select_field;
  wire        ext_level;
  wire        pin_level;
  wire        cmp_level;
  wire        capture_level;
  wire        capture_edge;
  wire        capture_top_mode;
  wire        phase_mode;
  wire        fast_mode;
  wire        ctc_mode;
  wire        wr_cnt_low;
  wire        wr_cap_low;
  wire        next_overflow_flag;
  wire        next_capture_flag;

  // ----------------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------------
  assign waveform_mode_field = {control_reg_b[`CTRLB_MODE_HI],
                                control_reg_a[`CTRLA_MODE_LO]};
  assign clock_select_field  = control_reg_b[`CTRLB_CLKSEL];

  // Mode classes; 13 is reserved and runs as normal
  assign capture_top_mode = (waveform_mode_field == 4'h8) || (waveform_mode_field == 4'hA) ||
                            (waveform_mode_field == 4'hC) || (waveform_mode_field == 4'hE);
  assign phase_mode = (waveform_mode_field >= 4'h1 && waveform_mode_field <= 4'h3) ||
                      (waveform_mode_field >= 4'h8 && waveform_mode_field <= 4'hB);
  assign fast_mode  = (waveform_mode_field >= 4'h5 && waveform_mode_field <= 4'h7) ||
                      (waveform_mode_field == 4'hE) || (waveform_mode_field == 4'hF);
  assign ctc_mode   = (waveform_mode_field == 4'h4) || (waveform_mode_field == 4'hC);

  // Top of sequence per mode
  always @* begin
    case (waveform_mode_field)
      4'h1, 4'h5:             top_value = `TOP_8BIT;
      4'h2, 4'h6:             top_value = `TOP_9BIT;
      4'h3, 4'h7:             top_value = `TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_a_top;
      4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_value;
      default:                top_value = `TOP_MAX;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Pin conditioning: every outside level is synchronised first
  // ----------------------------------------------------------------------------
  input_conditioner u_ext_clock (
    .clock     (clock),
    .nrst      (nrst),
    .raw_in    (ext_clock_pin),
    .filter_on (1'b0),
    .level_out (ext_level)
  );

  input_conditioner u_capture_pin (
    .clock     (clock),
    .nrst      (nrst),
    .raw_in    (capture_pin),
    .filter_on (control_reg_b[`CTRLB_FILTER_BIT]),
    .level_out (pin_level)
  );

  input_conditioner u_comparator (
    .clock     (clock),
    .nrst      (nrst),
    .raw_in    (comparator_output),
    .filter_on (control_reg_b[`CTRLB_FILTER_BIT]),
    .level_out (cmp_level)
  );

  // Source switch can itself look like an edge; software clears the flag after
  assign capture_level = (INSTANCE_ONE != 0 && comparator_capture_select) ?
                         cmp_level : pin_level;
  // Edge detector is idle while capture_value defines top
  assign capture_edge = !capture_top_mode &&
                        (control_reg_b[`CTRLB_EDGE_BIT] ?
                         (capture_level && !capture_prev) :
                         (!capture_level && capture_prev));

  // ----------------------------------------------------------------------------
  // Clock select: prescaler taps and synchronised external edges
  // ----------------------------------------------------------------------------
  always @* begin
    case (clock_select_field)
      `CS_STOP:     timer_tick = 1'b0;
      `CS_DIV1:     timer_tick = 1'b1;
      `CS_DIV8:     timer_tick = &prescale[2:0];
      `CS_DIV64:    timer_tick = &prescale[5:0];
      `CS_DIV256:   timer_tick = &prescale[7:0];
      `CS_DIV1024:  timer_tick = &prescale[9:0];
      `CS_EXT_FALL: timer_tick = ext_prev && !ext_level;
      `CS_EXT_RISE: timer_tick = !ext_prev && ext_level;
      default:      timer_tick = 1'b0;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale     <= 10'h000;
      ext_prev     <= 1'b0;
      capture_prev <= 1'b0;
    end else begin
      prescale     <= prescale + 10'h001;
      ext_prev     <= ext_level;
      capture_prev <= capture_level;
    end
  end

  // ----------------------------------------------------------------------------
  // Counter sequence
  // ----------------------------------------------------------------------------
  assign wr_cnt_low = io_wr && (io_addr == `OFS_COUNTER_LOWER);
  assign wr_cap_low = io_wr && (io_addr == `OFS_CAPTURE_LOWER) && capture_top_mode;

  always @* begin
    next_count     = count_value;
    next_down      = count_down;
    overflow_event = 1'b0;
    if (wr_cnt_low) begin
      next_count = {holding_byte, io_wdata};
    end else if (timer_tick) begin
      if (phase_mode) begin
        if (!count_down) begin
          if (count_value >= top_value) begin
            next_down  = 1'b1;
            next_count = count_value - 16'h0001;
          end else begin
            next_count = count_value + 16'h0001;
          end
        end else if (count_value == `RESET_WORD) begin
          next_down      = 1'b0;
          next_count     = 16'h0001;
          overflow_event = 1'b1;
        end else begin
          next_count = count_value - 16'h0001;
        end
      end else if (fast_mode || ctc_mode) begin
        next_down = 1'b0;
        if (count_value == top_value) begin
          next_count     = `RESET_WORD;
          overflow_event = fast_mode;
        end else begin
          next_count     = count_value + 16'h0001;
          overflow_event = (count_value == `TOP_MAX);
        end
      end else begin
        next_down      = 1'b0;
        next_count     = count_value + 16'h0001;
        overflow_event = (count_value == `TOP_MAX);
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_value <= `RESET_WORD;
      count_down  <= 1'b0;
      top_hit     <= 1'b0;
      bottom_hit  <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down  <= next_down;
      top_hit     <= (next_count == top_value);
      bottom_hit  <= (next_count == `RESET_WORD);
    end
  end

  // ----------------------------------------------------------------------------
  // Flags: a setting event wins over a clear in the same cycle
  // ----------------------------------------------------------------------------
  assign next_overflow_flag = overflow_event ||
    (overflow_flag && !overflow_irq_ack &&
     !(io_wr && io_addr == `OFS_FLAGS && io_wdata[`FLAG_OVERFLOW_BIT]));
  assign next_capture_flag = capture_edge ||
    (capture_flag && !capture_irq_ack &&
     !(io_wr && io_addr == `OFS_FLAGS && io_wdata[`FLAG_CAPTURE_BIT]));

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
      capture_flag  <= 1'b0;
      overflow_irq  <= 1'b0;
      capture_irq   <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
      capture_flag  <= next_capture_flag;
      overflow_irq  <= next_overflow_flag && overflow_irq_enable;
      capture_irq   <= next_capture_flag && capture_irq_enable;
    end
  end

  // ----------------------------------------------------------------------------
  // Capture register: hardware capture, or CPU write in capture-top modes
  // ----------------------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      capture_value <= `RESET_WORD;
    else if (capture_edge)
      capture_value <= count_value;
    else if (wr_cap_low)
      capture_value <= {holding_byte, io_wdata};
  end

  // ----------------------------------------------------------------------------
  // Control, mask and holding register writes
  // ----------------------------------------------------------------------------
  // The holding byte is one register for all words, so an interrupting
  // access between the two halves corrupts the outer access.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_reg_a             <= `RESET_BYTE;
      control_reg_b             <= `RESET_BYTE;
      holding_byte              <= `RESET_BYTE;
      overflow_irq_enable       <= 1'b0;
      capture_irq_enable        <= 1'b0;
      comparator_capture_select <= 1'b0;
    end else begin
      if (io_wr) begin
        case (io_addr)
          `OFS_CONTROL_A: control_reg_a <= io_wdata;
          `OFS_CONTROL_B: control_reg_b <= io_wdata;
          `OFS_COUNTER_UPPER,
          `OFS_CAPTURE_UPPER: holding_byte <= io_wdata;
          `OFS_MASK: begin
            overflow_irq_enable <= io_wdata[`FLAG_OVERFLOW_BIT];
            capture_irq_enable  <= io_wdata[`FLAG_CAPTURE_BIT];
          end
          `OFS_COMPARATOR_SEL:
            comparator_capture_select <= io_wdata[`CMPSEL_BIT] && (INSTANCE_ONE != 0);
          default: ;
        endcase
      end else if (io_rd) begin
        if (io_addr == `OFS_COUNTER_LOWER)
          holding_byte <= count_value[15:8];
        else if (io_addr == `OFS_CAPTURE_LOWER)
          holding_byte <= capture_value[15:8];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read data, registered; unmapped offsets read zero
  // ----------------------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= `RESET_BYTE;
    end else if (io_rd) begin
      case (io_addr)
        `OFS_CONTROL_A:      io_rdata <= control_reg_a;
        `OFS_CONTROL_B:      io_rdata <= control_reg_b;
        `OFS_COUNTER_LOWER:  io_rdata <= count_value[7:0];
        `OFS_COUNTER_UPPER:  io_rdata <= holding_byte;
        `OFS_CAPTURE_LOWER:  io_rdata <= capture_value[7:0];
        `OFS_CAPTURE_UPPER:  io_rdata <= holding_byte;
        `OFS_FLAGS:          io_rdata <= {2'b00, capture_flag, 4'h0, overflow_flag};
        `OFS_MASK:           io_rdata <= {2'b00, capture_irq_enable, 4'h0,
                                          overflow_irq_enable};
        `OFS_COMPARATOR_SEL: io_rdata <= {7'h00, comparator_capture_select};
        default:             io_rdata <= `RESET_BYTE;
      endcase
    end
  end

endmodule // timer16_counter_capture

// File: cpu_bus.sv
// Model of the CPU core that drives the timer's byte-wide I/O bus
`timescale 1ns/10ps

module cpu_bus (
  input  wire       clock,
  output reg  [5:0] io_addr,
  output reg  [7:0] io_wdata,
  output reg        io_wr,
  output reg        io_rd,
  input  wire [7:0] io_rdata
);
  // Idle bus at time zero
  initial begin
    io_addr = 6'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end

  // Single byte write; data inverted once released so stale values never look valid
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge clock);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge clock);
      io_wr <= 1'b0;
      io_wdata <= ~d;
    end
  endtask

  // Word write: upper location first, lower back to back so the word lands at once
  task wr16(input [5:0] lo, input [15:0] v);
    begin
      @(posedge clock);
      io_addr <= lo + 6'h01;
      io_wdata <= v[15:8];
      io_wr <= 1'b1;
      @(posedge clock);
      io_addr <= lo;
      io_wdata <= v[7:0];
      @(posedge clock);
      io_wr <= 1'b0;
    end
  endtask

  // Single byte read; data taken mid-cycle once the registered answer has settled
  task rd(input [5:0] a, output [7:0] d);
    begin
      @(posedge clock);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clock);
      io_rd <= 1'b0;
      @(negedge clock);
      d = io_rdata;
    end
  endtask

  // Word read: lower first latches the upper byte into the holding register
  task rd16(input [5:0] lo, output [15:0] v);
    begin
      @(posedge clock);
      io_addr <= lo;
      io_rd <= 1'b1;
      @(posedge clock);
      io_addr <= lo + 6'h01;
      @(negedge clock);
      v[7:0] = io_rdata;
      @(posedge clock);
      io_rd <= 1'b0;
      @(negedge clock);
      v[15:8] = io_rdata;
    end
  endtask
endmodule // cpu_bus

// File: timer16_counter_capture_chk.sv
// Concurrent assertions on the ports of the 16-bit timer counter
`timescale 1ns/10ps
`include "timer16_defines.vh"

module timer16_chk (
  input wire        clock,
  input wire        nrst,
  input wire [5:0]  io_addr,
  input wire [7:0]  io_wdata,
  input wire        io_wr,
  input wire        io_rd,
  input wire [7:0]  io_rdata,
  input wire        capture_pin,
  input wire        capture_irq_ack,
  input wire        capture_irq,
  input wire [15:0] count_value,
  input wire        bottom_hit
);
  // ---------------------------------------------------------------------------
  // Shadow of the control fields, rebuilt from bus writes
  // ---------------------------------------------------------------------------
  logic [2:0] cs_m;
  logic [3:0] mode_m;
  logic       edge_m;
  logic       filt_m;
  logic       cen_m;
  logic       cmp_m;
  wire [7:0]  cnt_hi = count_value[15:8];
  wire [7:0]  cnt_lo = count_value[7:0];
  wire        wr_lo = io_wr && io_addr == `OFS_COUNTER_LOWER;
  wire        wr_hi = io_wr && io_addr == `OFS_COUNTER_UPPER;
  wire        clr_w = io_wr && io_addr == `OFS_FLAGS;
  // Capture is only armed outside the modes that use the capture word as top
  wire        armed = cen_m && !cmp_m && !(mode_m[3] && !mode_m[0]) && !capture_irq;

  // Mirror updates on the same edge as the design's registers
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_m <= 3'h0;
      mode_m <= 4'h0;
      edge_m <= 1'b0;
      filt_m <= 1'b0;
      cen_m <= 1'b0;
      cmp_m <= 1'b0;
    end else if (io_wr) begin
      if (io_addr == `OFS_CONTROL_A) mode_m[1:0] <= io_wdata[`CTRLA_MODE_LO];
      if (io_addr == `OFS_CONTROL_B) begin
        cs_m <= io_wdata[`CTRLB_CLKSEL];
        mode_m[3:2] <= io_wdata[`CTRLB_MODE_HI];
        edge_m <= io_wdata[`CTRLB_EDGE_BIT];
        filt_m <= io_wdata[`CTRLB_FILTER_BIT];
      end
      if (io_addr == `OFS_MASK) cen_m <= io_wdata[`FLAG_CAPTURE_BIT];
      if (io_addr == `OFS_COMPARATOR_SEL) cmp_m <= io_wdata[`CMPSEL_BIT];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  chk_word_write: assert property (wr_hi ##1 wr_lo |=>
    count_value == {$past(io_wdata, 2), $past(io_wdata)}) else $error("word write wrong");
  chk_low_read: assert property (io_rd && io_addr == `OFS_COUNTER_LOWER |=>
    io_rdata == $past(cnt_lo)) else $error("low byte read wrong");
  chk_high_read: assert property (io_rd && io_addr == `OFS_COUNTER_LOWER ##1
    io_rd && io_addr == `OFS_COUNTER_UPPER |=> io_rdata == $past(cnt_hi, 2))
    else $error("latched upper byte wrong");
  chk_count_step: assert property (cs_m == 3'h1 && mode_m == 4'h0 && !io_wr |=>
    count_value == $past(count_value) + 16'h0001) else $error("count step wrong");
  chk_stop_hold: assert property (cs_m == 3'h0 && !io_wr |=> $stable(count_value))
    else $error("stopped counter moved");
  chk_cap_timing: assert property ($rose(capture_pin) && edge_m && !filt_m && armed &&
    !io_wr |-> ##4 capture_irq) else $error("capture late or missing");
  chk_cap_filter: assert property ($fell(capture_pin) && !edge_m && filt_m && armed &&
    !io_wr |-> ##8 capture_irq) else $error("filtered capture late or missing");
  chk_flag_clear: assert property (clr_w && io_wdata[`FLAG_CAPTURE_BIT] |=> !capture_irq)
    else $error("write one did not clear");
  chk_flag_keep: assert property (clr_w && !io_wdata[`FLAG_CAPTURE_BIT] && capture_irq &&
    !capture_irq_ack |=> capture_irq) else $error("write zero cleared flag");
  chk_ack_clear: assert property (capture_irq_ack |=> !capture_irq)
    else $error("service did not clear");
  chk_bottom_mark: assert property ($stable(count_value) ##1 $stable(count_value) |->
    bottom_hit == (count_value == 16'h0000)) else $error("bottom mark wrong");

  cover property ($rose(capture_irq));
  cover property (wr_hi ##1 wr_lo);
  cover property ($rose(bottom_hit));
endmodule // timer16_chk

bind timer16_counter_capture timer16_chk timer16_chk_i (
  .clock           (clock),
  .nrst            (nrst),
  .io_addr         (io_addr),
  .io_wdata        (io_wdata),
  .io_wr           (io_wr),
  .io_rd           (io_rd),
  .io_rdata        (io_rdata),
  .capture_pin     (capture_pin),
  .capture_irq_ack (capture_irq_ack),
  .capture_irq     (capture_irq),
  .count_value     (count_value),
  .bottom_hit      (bottom_hit)
);

// File: test_timer16_counter_capture.sv
// Self-checking testbench for the 16-bit timer counter with capture
`timescale 1ns/10ps
`include "timer16_defines.vh"

module test_timer16_counter_capture;
  logic        clock;
  logic        nrst;
  logic        capture_pin;
  logic        comparator_output;
  logic        ext_clock_pin;
  logic        overflow_irq_ack;
  logic        capture_irq_ack;
  wire  [5:0]  io_addr;
  wire  [7:0]  io_wdata;
  wire  [7:0]  io_rdata;
  wire         io_wr;
  wire         io_rd;
  wire         overflow_irq;
  wire         capture_irq;
  wire         top_hit;
  wire         bottom_hit;
  wire         count_down;
  wire  [15:0] count_value;
  logic [15:0] w;
  logic [7:0]  b;
  int          n_errors;
  int          comparisons;

  timer16_counter_capture timer16_counter_capture_i (
    .clock(clock), .nrst(nrst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .ext_clock_pin(ext_clock_pin),
    .compare_a_top(16'h00FF), .overflow_irq_ack(overflow_irq_ack),
    .capture_irq_ack(capture_irq_ack), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .count_value(count_value), .top_hit(top_hit), .bottom_hit(bottom_hit),
    .count_down(count_down));

  cpu_bus cpu_bus_i (.clock(clock), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata));

  // 40 MHz system clock
  always #12.5 clock = ~clock;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      comparisons++;
      if (seen !== exp) begin
        n_errors++;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task conclude;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Bounded wait: 0 capture irq, 1 overflow irq, 2 top mark, 3 down direction
  task wait_for(input int sel);
    int i;
    logic s;
    begin
      for (i = 0; i < 400; i++) begin
        @(posedge clock);
        s = (sel == 0) ? capture_irq : (sel == 1) ? overflow_irq : (sel == 2) ? top_hit : count_down;
        if (s === 1'b1) break;
      end
      if (i == 400) begin
        check(16'h0000, 16'h0001);
        conclude();
      end
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    ext_clock_pin = 1'b0;
    overflow_irq_ack = 1'b0;
    capture_irq_ack = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    cpu_bus_i.rd(6'h3F, b);
    check(b, 8'h00);
    // Word access through the holding byte while stopped
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'h01FF);
    @(negedge clock);
    check(count_value, 16'h01FF);
    cpu_bus_i.rd16(`OFS_COUNTER_LOWER, w);
    check(w, 16'h01FF);
    cpu_bus_i.rd(`OFS_CAPTURE_UPPER, b);
    check(b, 8'h01);
    cpu_bus_i.wr(`OFS_COUNTER_UPPER, 8'h12);
    cpu_bus_i.wr(`OFS_COUNTER_LOWER, 8'h34);
    @(negedge clock);
    check(count_value, 16'h1234);
    cpu_bus_i.wr(`OFS_COUNTER_LOWER, 8'h56);
    @(negedge clock);
    check(count_value, 16'h1256);
    // Rising capture with the counter frozen, so the stamp is known
    cpu_bus_i.wr(`OFS_MASK, 8'h21);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h40);
    capture_pin <= 1'b1;
    wait_for(0);
    cpu_bus_i.rd16(`OFS_CAPTURE_LOWER, w);
    check(w, 16'h1256);
    cpu_bus_i.wr(`OFS_FLAGS, 8'h01);
    @(negedge clock);
    check(capture_irq, 1'b1);
    cpu_bus_i.wr(`OFS_FLAGS, 8'h20);
    @(negedge clock);
    check(capture_irq, 1'b0);
    // Falling capture through the noise filter, then serviced
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'h0777);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h80);
    capture_pin <= 1'b0;
    wait_for(0);
    cpu_bus_i.rd16(`OFS_CAPTURE_LOWER, w);
    check(w, 16'h0777);
    @(posedge clock);
    capture_irq_ack <= 1'b1;
    @(posedge clock);
    capture_irq_ack <= 1'b0;
    @(negedge clock);
    check(capture_irq, 1'b0);
    // Comparator as trigger; flag cleared after the source switch
    cpu_bus_i.wr(`OFS_COMPARATOR_SEL, 8'h01);
    cpu_bus_i.rd(`OFS_COMPARATOR_SEL, b);
    check(b, 8'h01);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h40);
    repeat (8) @(posedge clock);
    cpu_bus_i.wr(`OFS_FLAGS, 8'h20);
    comparator_output <= 1'b1;
    wait_for(0);
    check(capture_irq, 1'b1);
    cpu_bus_i.wr(`OFS_FLAGS, 8'h20);
    // Capture word refuses writes in mode 0, takes them in mode 12
    cpu_bus_i.wr16(`OFS_CAPTURE_LOWER, 16'h7788);
    cpu_bus_i.rd16(`OFS_CAPTURE_LOWER, w);
    check(w, 16'h0777);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h18);
    cpu_bus_i.wr16(`OFS_CAPTURE_LOWER, 16'h0005);
    cpu_bus_i.rd16(`OFS_CAPTURE_LOWER, w);
    check(w, 16'h0005);
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'h0000);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h19);
    wait_for(2);
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(count_value <= 16'h0005, 1'b1);
    // Normal mode wrap sets overflow; a word write while running wins
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h00);
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'hFFFD);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h01);
    wait_for(1);
    cpu_bus_i.rd(`OFS_FLAGS, b);
    check(b[`FLAG_OVERFLOW_BIT], 1'b1);
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'h4000);
    @(negedge clock);
    check(count_value, 16'h4000);
    @(negedge clock);
    check(count_value, 16'h4001);
    @(posedge clock);
    overflow_irq_ack <= 1'b1;
    @(posedge clock);
    overflow_irq_ack <= 1'b0;
    @(negedge clock);
    check(overflow_irq, 1'b0);
    // External rising-edge clock source: three pulses give three steps
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h07);
    @(negedge clock);
    w = count_value;
    repeat (3) begin
      @(posedge clock);
      ext_clock_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clock_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    @(negedge clock);
    check(count_value, w + 16'h0003);
    // Phase-correct 8-bit mode turns round at its top
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h00);
    cpu_bus_i.wr(`OFS_CONTROL_A, 8'h01);
    cpu_bus_i.wr16(`OFS_COUNTER_LOWER, 16'h00FD);
    cpu_bus_i.wr(`OFS_CONTROL_B, 8'h01);
    wait_for(3);
    @(negedge clock);
    check(count_value <= 16'h00FF, 1'b1);
    conclude();
  end
endmodule // test_timer16_counter_capture
